// file: verilog/sapc_params.svh
// timing constants and field positions for the SAR converter control block
// assumes a 100 MHz system clock on CLK_SYS
// Operation
// - Every sample yields one 16-bit result
// - First strobe fall, select low: acquire
// - First strobe fall with select high ignored
// - Second fall ends acquisition, starts conversion
// - Select at second fall: standby/shutdown
// - Standby keeps reference powered
// - Shutdown powers reference off after conversion
// - Standby plus fall, select low: acquire
// - Shutdown plus fall wakes reference, acquire
// - Conversion done within 4.7us
// - End flag low when result valid
// - Data outputs float during acquire, convert
// - Third fall, select high: drive result
// - Strobe high floats the bus
// - After read wait for next fall
// - Upper select picks high byte
// - Result in offset binary
`ifndef SAPC_PARAMS_SVH
`define SAPC_PARAMS_SVH
`define SAPC_CLK_PERIOD_NS 10
`define SAPC_CONV_TIME_NS 4700
`define SAPC_CONV_CYCLES (`SAPC_CONV_TIME_NS / `SAPC_CLK_PERIOD_NS)
`define SAPC_RESULT_BITS 16
`define SAPC_BYTE_BITS 8
`define SAPC_HIGH_LSB 8
`define SAPC_MIDSCALE 16'h8000
`endif

// file: verilog/sapc_pkg.sv
// types shared by the converter control files
package sapc_pkg;
  typedef enum logic [2:0] {
    SAPC_OFF     = 3'b000,
    SAPC_ACQUIRE = 3'b001,
    SAPC_CONVERT = 3'b011,
    SAPC_DONE    = 3'b010,
    SAPC_READ    = 3'b110
  } sapc_state_t;
endpackage : sapc_pkg

// file: verilog/sapc_sar_if.sv
// handshake between sequencer and SAR engine
// assumes one clock domain
`timescale 1ns/1ns
`default_nettype none
interface sapc_sar_if;
  logic start;
  logic done;
  logic [15:0] code;
  modport seq (output start, input done, input code);
  modport eng (input start, output done, output code);
endinterface : sapc_sar_if
`default_nettype wire

// file: verilog/sapc_sar.sv
// successive-approximation engine; comparator decision comes from outside
// assumes comparator input is already synchronous
`timescale 1ns/1ns
`default_nettype none
`include "sapc_params.svh"
module sapc_sar (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // comparator: 1 when held sample above trial level
  input wire logic cmp_above,
  // sequencer side
  sapc_sar_if.eng sar
);
  localparam int STEP_CYCLES = `SAPC_CONV_CYCLES / 20;
  logic [15:0] trial;
  logic [15:0] bit_mask;
  logic [7:0] pace;
  logic busy;

  // bits resolved msb first; each decision gets a fixed settle time
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trial <= 16'h0000;
      bit_mask <= 16'h0000;
      pace <= 8'h00;
      busy <= 1'b0;
      sar.done <= 1'b0;
      sar.code <= 16'h0000;
    end
    else
    begin
      sar.done <= 1'b0;
      if (sar.start)
      begin
        trial <= `SAPC_MIDSCALE;
        bit_mask <= `SAPC_MIDSCALE;
        pace <= 8'h00;
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (pace != 8'(STEP_CYCLES - 1))
          pace <= pace + 8'h01;
        else
        begin
          pace <= 8'h00;
          // offset binary: all-zero is most negative, midscale is zero
          if (bit_mask == 16'h0001)
          begin
            sar.code <= cmp_above ? trial : (trial & ~bit_mask);
            sar.done <= 1'b1;
            busy <= 1'b0;
          end
          else
          begin
            trial <= (cmp_above ? trial : (trial & ~bit_mask)) | (bit_mask >> 1);
            bit_mask <= bit_mask >> 1;
          end
        end
      end
    end
  end
endmodule : sapc_sar
`default_nettype wire

// file: verilog/sapc_ctrl.sv
// converter control sequencer and byte-wide tri-state result port
// assumes strobe pins asynchronous to CLK_SYS; bus wire resolved outside
`timescale 1ns/1ns
`default_nettype none
`include "sapc_params.svh"
module sapc_ctrl (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // host control pins
  input wire logic CONVERT_STROBE_N,
  input wire logic READ_CONVERT_SEL,
  input wire logic UPPER_BYTE_SELECT,
  // comparator decision from analog front end
  input wire logic CMP_ABOVE,
  // result bus, enable low while driving
  output logic [7:0] RESULT_BITS_O,
  output logic RESULT_BITS_OE_N,
  // status and analog controls
  output logic END_OF_CONV_N,
  output logic TRACK_HOLD_CLOSED,
  output logic CORE_POWER_ON,
  output logic REFERENCE_ON
);
  logic [1:0] strobe_sync;
  logic [1:0] sel_sync;
  logic [1:0] upper_sync;
  logic strobe_prev;
  logic strobe_fall;
  logic strobe_rise;
  logic shutdown_next;
  logic [15:0] result;
  sapc_pkg::sapc_state_t state;
  sapc_pkg::sapc_state_t next_state;
  sapc_sar_if sar_bus ();

  // pins pass two flops; only the second stage is used
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      strobe_sync <= 2'h3;
      sel_sync <= 2'h0;
      upper_sync <= 2'h0;
      strobe_prev <= 1'b1;
    end
    else
    begin
      strobe_sync <= {strobe_sync[0], CONVERT_STROBE_N};
      sel_sync <= {sel_sync[0], READ_CONVERT_SEL};
      upper_sync <= {upper_sync[0], UPPER_BYTE_SELECT};
      strobe_prev <= strobe_sync[1];
    end
  end

  assign strobe_fall = strobe_prev & ~strobe_sync[1];
  assign strobe_rise = ~strobe_prev & strobe_sync[1];

  always_comb
  begin
    next_state = state;
    case (state)
      sapc_pkg::SAPC_OFF,
      sapc_pkg::SAPC_DONE:
        if (strobe_fall && !sel_sync[1])
          next_state = sapc_pkg::SAPC_ACQUIRE;
        else if (strobe_fall && state == sapc_pkg::SAPC_DONE)
          next_state = sapc_pkg::SAPC_READ;
      sapc_pkg::SAPC_ACQUIRE:
        if (strobe_fall)
          next_state = sapc_pkg::SAPC_CONVERT;
      sapc_pkg::SAPC_CONVERT:
        if (sar_bus.done)
          next_state = sapc_pkg::SAPC_DONE;
      sapc_pkg::SAPC_READ:
        if (strobe_rise)
          next_state = sapc_pkg::SAPC_DONE;
      default:
        next_state = sapc_pkg::SAPC_OFF;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      state <= sapc_pkg::SAPC_OFF;
    else
      state <= next_state;
  end

  // power mode is chosen by select level at the conversion-start edge
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      shutdown_next <= 1'b1;
    else if (state == sapc_pkg::SAPC_ACQUIRE && strobe_fall)
      shutdown_next <= sel_sync[1];
  end

  assign sar_bus.start = (state == sapc_pkg::SAPC_ACQUIRE) && strobe_fall;

  sapc_sar u_sar (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .cmp_above(CMP_ABOVE),
    .sar(sar_bus.eng)
  );

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      result <= 16'h0000;
    else if (sar_bus.done)
      result <= sar_bus.code;
  end

  // analog power controls; reference stays up in standby
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      CORE_POWER_ON <= 1'b0;
      REFERENCE_ON <= 1'b0;
      TRACK_HOLD_CLOSED <= 1'b0;
    end
    else
    begin
      TRACK_HOLD_CLOSED <= (next_state == sapc_pkg::SAPC_ACQUIRE);
      if (next_state == sapc_pkg::SAPC_ACQUIRE)
      begin
        CORE_POWER_ON <= 1'b1;
        REFERENCE_ON <= 1'b1;
      end
      else if (state == sapc_pkg::SAPC_CONVERT && sar_bus.done)
      begin
        CORE_POWER_ON <= !shutdown_next;
        REFERENCE_ON <= !shutdown_next;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      END_OF_CONV_N <= 1'b1;
    else if (next_state == sapc_pkg::SAPC_ACQUIRE)
      END_OF_CONV_N <= 1'b1;
    else if (state == sapc_pkg::SAPC_CONVERT && sar_bus.done)
      END_OF_CONV_N <= 1'b0;
  end

  // byte select followed live while driving
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      RESULT_BITS_O <= 8'h00;
      RESULT_BITS_OE_N <= 1'b1;
    end
    else
    begin
      RESULT_BITS_OE_N <= (next_state != sapc_pkg::SAPC_READ);
      RESULT_BITS_O <= upper_sync[1] ? result[15:8] : result[7:0];
    end
  end

  a_float_outside_read: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_ACQUIRE || state == sapc_pkg::SAPC_CONVERT) |-> RESULT_BITS_OE_N)
    else $error("bus driven during acquire or convert");
  a_conv_time_bound: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    sar_bus.start |-> ##[1:469] (state == sapc_pkg::SAPC_CONVERT && sar_bus.done))
    else $error("conversion too slow");
  a_eoc_on_done: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_CONVERT && sar_bus.done) |=> !END_OF_CONV_N)
    else $error("end flag not low after conversion");
  a_ignore_high_sel: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_OFF && strobe_fall && sel_sync[1]) |=>
      state == sapc_pkg::SAPC_OFF)
    else $error("start with select high not ignored");
  a_start_acquire: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_OFF && strobe_fall && !sel_sync[1]) |=> ##1
      (TRACK_HOLD_CLOSED && REFERENCE_ON))
    else $error("acquire not entered");
  a_shutdown_ref: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_CONVERT && sar_bus.done && shutdown_next) |=> !REFERENCE_ON)
    else $error("reference left on in shutdown");
  a_standby_ref: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_CONVERT && sar_bus.done && !shutdown_next) |=> REFERENCE_ON)
    else $error("reference dropped in standby");
  a_read_drives: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_DONE && strobe_fall && sel_sync[1]) |=> !RESULT_BITS_OE_N)
    else $error("read did not drive bus");
  a_release_bus: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_READ && strobe_rise) |=> RESULT_BITS_OE_N)
    else $error("bus not released");
  a_byte_pick: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (!RESULT_BITS_OE_N && $stable(upper_sync[1]) && $stable(result)) |->
      RESULT_BITS_O == (upper_sync[1] ? result[15:8] : result[7:0]))
    else $error("wrong byte on bus");

  // checker helpers; the conversion bound is too long for a delay range alone
  logic [9:0] conv_age;
  logic saw_done;

  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      conv_age <= 10'h000;
    else if (sar_bus.start)
      conv_age <= 10'h001;
    else if (state == sapc_pkg::SAPC_CONVERT && conv_age != 10'h3FF)
      conv_age <= conv_age + 10'h001;
  end

  // a read is only legal once a result has been produced
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      saw_done <= 1'b0;
    else if (sar_bus.done)
      saw_done <= 1'b1;
    else if (sar_bus.start)
      saw_done <= 1'b0;
  end

  // conversion timing and end flag
  a_conv_age_limit: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_CONVERT) |->
      (conv_age <= 10'(`SAPC_CONV_CYCLES)))
    else $error("conversion ran past its bound");

  a_eoc_high_busy: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_ACQUIRE || state == sapc_pkg::SAPC_CONVERT) |->
      END_OF_CONV_N)
    else $error("end flag low while busy");

  a_eoc_low_ready: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_DONE || state == sapc_pkg::SAPC_READ) |->
      !END_OF_CONV_N)
    else $error("end flag high with result ready");

  a_done_once: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    sar_bus.done |=>
      !sar_bus.done)
    else $error("engine done longer than one cycle");

  a_sar_idle_acq: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_ACQUIRE) |->
      !sar_bus.done)
    else $error("engine finished during acquisition");

  // track-and-hold and phase order
  a_th_closed_acq: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_ACQUIRE) |->
      TRACK_HOLD_CLOSED)
    else $error("track-and-hold open in acquisition");

  a_acq_stays: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_ACQUIRE && !strobe_fall) |=>
      (state == sapc_pkg::SAPC_ACQUIRE))
    else $error("acquisition left without strobe");

  a_th_open_convert: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_CONVERT) |->
      !TRACK_HOLD_CLOSED)
    else $error("track-and-hold closed in conversion");

  a_convert_entry: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_ACQUIRE && strobe_fall) |=>
      (state == sapc_pkg::SAPC_CONVERT && !TRACK_HOLD_CLOSED))
    else $error("conversion not started");

  a_off_quiet: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_OFF) |->
      (RESULT_BITS_OE_N && END_OF_CONV_N && !TRACK_HOLD_CLOSED))
    else $error("idle device not quiet");

  a_acq_from_done: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_DONE && strobe_fall && !sel_sync[1]) |=>
      (state == sapc_pkg::SAPC_ACQUIRE))
    else $error("no acquisition from standby");

  // power modes
  a_sel_latched: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_ACQUIRE && strobe_fall) |=>
      (shutdown_next == $past(sel_sync[1])))
    else $error("power mode not latched");

  a_power_acquire: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_ACQUIRE) |->
      (CORE_POWER_ON && REFERENCE_ON))
    else $error("unpowered during acquisition");

  a_ref_up_convert: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_CONVERT) |->
      REFERENCE_ON)
    else $error("reference off during conversion");

  a_mode_power: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_DONE || state == sapc_pkg::SAPC_READ) |->
      (REFERENCE_ON == !shutdown_next))
    else $error("reference does not follow power mode");

  a_shutdown_core: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    ((state == sapc_pkg::SAPC_DONE || state == sapc_pkg::SAPC_READ) && shutdown_next) |->
      !CORE_POWER_ON)
    else $error("core left on in shutdown");

  // result and bus
  a_result_on_done: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    sar_bus.done |=>
      (result == $past(sar_bus.code)))
    else $error("result not captured");

  a_result_kept: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    !sar_bus.done |=>
      $stable(result))
    else $error("result changed without conversion");

  a_bus_float_done: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_DONE) |->
      RESULT_BITS_OE_N)
    else $error("bus driven outside read");

  a_drive_in_read: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_READ) |->
      !RESULT_BITS_OE_N)
    else $error("bus not driven in read");

  a_read_holds: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_READ && !strobe_rise) |=>
      (state == sapc_pkg::SAPC_READ && !RESULT_BITS_OE_N))
    else $error("read ended without strobe rise");

  a_read_after_done: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_READ) |->
      saw_done)
    else $error("read without a result");

  a_no_read_early: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (state == sapc_pkg::SAPC_ACQUIRE && strobe_fall && sel_sync[1]) |=>
      RESULT_BITS_OE_N)
    else $error("bus driven at conversion start");

  a_upper_byte: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (!RESULT_BITS_OE_N && $past(upper_sync[1]) && $stable(result)) |->
      (RESULT_BITS_O == result[15:8]))
    else $error("upper byte not on bus");

  a_lower_byte: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    (!RESULT_BITS_OE_N && !$past(upper_sync[1]) && $stable(result)) |->
      (RESULT_BITS_O == result[7:0]))
    else $error("lower byte not on bus");
endmodule : sapc_ctrl
`default_nettype wire

// file: tb/sapc_host.sv
// controller model on the far side of the converter pins
// assumes the converter samples its pins on the clock given here
`timescale 1ns/1ns
`default_nettype none
module sapc_host #(
  parameter int WAKE = 40
) (
  // clock
  input wire logic clk,
  // pins toward the converter
  output logic strobe_n,
  output logic sel,
  output logic ubs,
  output logic cmp
);
  initial
  begin
    strobe_n = 1'b1;
    sel = 1'b0;
    ubs = 1'b0;
    cmp = 1'b0;
  end
  // each level held 8 cycles so the pin synchroniser cannot miss it
  task automatic pulse(input logic s, input logic u);
    @(posedge clk);
    strobe_n <= 1'b0;
    sel <= s;
    ubs <= u;
    repeat (8) @(posedge clk);
    strobe_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : pulse
  // reference wake time, shortened so the run stays brief
  task automatic settle();
    repeat (WAKE) @(posedge clk);
  endtask : settle
  task automatic set_cmp(input logic c);
    @(posedge clk);
    cmp <= c;
  endtask : set_cmp
endmodule : sapc_host
`default_nettype wire

// file: tb/test_sapc_ctrl.sv
// self-checking bench for the converter control sequencer
// assumes sapc_host as the controller driving the pins
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_sapc_ctrl;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire strobe_n, sel, ubs, cmp;
  wire [7:0] data;
  wire oe_n, eoc_n, th, pwr, ref_on;
  int err_count = 0;
  int checks_done = 0;
  logic [7:0] notes[$];
  int n;
  logic c;
  always #5 clk = ~clk;
  sapc_host host (.clk(clk), .strobe_n(strobe_n), .sel(sel), .ubs(ubs), .cmp(cmp));
  sapc_ctrl dut (.CLK_SYS(clk), .SYS_RST(rst), .CONVERT_STROBE_N(strobe_n),
    .READ_CONVERT_SEL(sel), .UPPER_BYTE_SELECT(ubs), .CMP_ABOVE(cmp),
    .RESULT_BITS_O(data), .RESULT_BITS_OE_N(oe_n), .END_OF_CONV_N(eoc_n),
    .TRACK_HOLD_CLOSED(th), .CORE_POWER_ON(pwr), .REFERENCE_ON(ref_on));
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // each bus drive must match the oldest expected byte
  always @(negedge oe_n)
  begin
    repeat (2) @(posedge clk);
    #1;
    `CHK(notes.size() > 0, 1'b1)
    `CHK(data, notes.pop_front())
  end
  initial
  begin
    #100000;
    err_count++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'hA8DB));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({oe_n, eoc_n, ref_on}, 3'b110)
    host.pulse(1'b1, 1'b0);
    `CHK({th, pwr, oe_n}, 3'b001)
    // odd passes pick shutdown, so even passes wake from it
    for (int k = 0; k < 4; k++)
    begin
      c = 1'($urandom % 2);
      host.set_cmp(c);
      host.pulse(1'b0, 1'b0);
      `CHK({th, pwr, ref_on, oe_n}, 4'hF)
      host.settle();
      host.pulse(k[0], 1'b0);
      `CHK({th, oe_n}, 2'b01)
      // upper eight decisions see c, lower eight its inverse
      repeat (180) @(posedge clk);
      host.set_cmp(~c);
      n = 198;
      while (eoc_n !== 1'b0 && n < 600)
      begin
        @(posedge clk);
        n++;
      end
      `CHK(n <= 475, 1'b1)
      repeat (2) @(posedge clk);
      `CHK(ref_on, ~k[0])
      notes.push_back({8{~c}});
      host.pulse(1'b1, 1'b0);
      `CHK(oe_n, 1'b1)
      notes.push_back({8{c}});
      host.pulse(1'b1, 1'b1);
      `CHK({oe_n, eoc_n, notes.size() == 0}, 3'b101)
    end
    give_verdict();
  end
endmodule : test_sapc_ctrl
`default_nettype wire
